// [hdl/smr_pkg.sv]
// constants, field layout and register map of the mode register write controller
package smr_pkg;

    // clock and timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int TWR_NS = 15;
    localparam int WR_CYCLES = (TWR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WR_CODE_BIAS = 1;
    localparam logic [2:0] WR_CODE = 3'(WR_CYCLES - WR_CODE_BIAS);
    localparam int REGISTER_WRITE_CYCLE_TIME_CYCLES = 2;
    localparam int DLL_LOCK_CYCLES = 200;
    localparam int CNT_W = 8;
    localparam logic [CNT_W-1:0] REGISTER_WRITE_CYCLE_TIME_LOAD = CNT_W'(REGISTER_WRITE_CYCLE_TIME_CYCLES - 1);
    localparam logic [CNT_W-1:0] DLL_LOAD = CNT_W'(DLL_LOCK_CYCLES);

    // software register map
    localparam logic [7:0] ADDR_CMD = 8'h00;
    localparam logic [7:0] ADDR_MAIN = 8'h04;
    localparam logic [7:0] ADDR_EXT1 = 8'h08;
    localparam logic [7:0] ADDR_EXT2 = 8'h0c;
    localparam logic [7:0] ADDR_STATUS = 8'h10;

    // command register fields
    localparam int CMD_TGT_LSB = 0;
    localparam int CMD_CAL_BIT = 2;
    localparam int CMD_CODE_LSB = 3;

    // status register fields
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_READ_OK_BIT = 1;
    localparam int ST_REFUSED_BIT = 2;
    localparam int ST_SREF_OK_BIT = 3;
    localparam int ST_PEND_EXIT_BIT = 4;

    // device register targets on the bank bits
    localparam logic [1:0] TGT_MAIN = 2'h0;
    localparam logic [1:0] TGT_EXT1 = 2'h1;
    localparam logic [1:0] TGT_EXT2 = 2'h2;
    localparam logic [1:0] TGT_EXT3 = 2'h3;

    // address field layout
    localparam int ADDR_W = 13;
    localparam int BL_LSB = 0;
    localparam int TEST_BIT = 7;
    localparam int DLL_RESET_BIT = 8;
    localparam int WR_LSB = 9;
    localparam int AL_LSB = 3;
    localparam int CAL_LSB = 7;
    localparam int HOT_BIT = 7;
    localparam logic [2:0] BL_FOUR = 3'h2;
    localparam logic [2:0] BL_EIGHT = 3'h3;

    // software writable bits of the main and ext1 shadows
    localparam logic [ADDR_W-1:0] MAIN_SW_MASK = 13'h017f;
    localparam logic [ADDR_W-1:0] EXT1_SW_MASK = 13'h0c7f;
    localparam logic [ADDR_W-1:0] MAIN_RESET = 13'h0032;
    localparam logic [ADDR_W-1:0] EXT1_RESET = 13'h0000;
    localparam logic [ADDR_W-1:0] ZERO_WORD = 13'h0000;

    // driver calibration codes
    localparam logic [2:0] CAL_EXIT = 3'h0;
    localparam logic [2:0] CAL_DRIVE_HIGH = 3'h1;
    localparam logic [2:0] CAL_DRIVE_LOW = 3'h2;
    localparam logic [2:0] CAL_ADJUST = 3'h4;
    localparam logic [2:0] CAL_DEFAULT = 3'h7;

    typedef enum logic {
        ST_IDLE = 1'b0,
        ST_WAIT = 1'b1
    } smr_state_e;

endpackage

// [hdl/smr_wait_cnt.sv]
// loadable down counter that reports when it has run out
`timescale 1ns/100ps
module smr_wait_cnt #(
    parameter int W = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // control
    input wire logic load,
    input wire logic [W-1:0] loadValue,
    // state
    output logic [W-1:0] value,
    output logic done
);

    logic [W-1:0] cnt_q;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt_q <= '0;
        end else if (load) begin
            cnt_q <= loadValue;
        end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - 1'b1;
        end
    end

    assign value = cnt_q;
    assign done = (cnt_q == '0);

endmodule // smr_wait_cnt

// [hdl/smr_ctrl.sv]
// controller that programs the mode and extended mode registers of a ddr2 memory
`timescale 1ns/100ps
module smr_ctrl (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // software register port
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdData,
    // memory controller status
    input wire logic banksPrecharged,
    input wire logic clkEnHigh,
    input wire logic hotCase,
    input wire logic selfRefreshExit,
    output logic readAllowed,
    output logic selfRefreshOk,
    // memory command pins
    output logic ddrCsN,
    output logic ddrRasN,
    output logic ddrCasN,
    output logic ddrWeN,
    output logic [1:0] ddrBa,
    output logic [12:0] ddrAddr
);

    smr_pkg::smr_state_e state_q;
    logic [smr_pkg::ADDR_W-1:0] mainCfg_q;
    logic [smr_pkg::ADDR_W-1:0] ext1Cfg_q;
    logic ext2Hot_q;
    logic ext2HotSent_q;
    logic pendExit_q;
    logic refused_q;
    logic [31:0] rdData_q;
    logic csN_q;
    logic [1:0] ba_q;
    logic [smr_pkg::ADDR_W-1:0] addr_q;

    logic cmdWr;
    logic [1:0] cmdTgt;
    logic cmdCal;
    logic [2:0] cmdCode;
    logic codeOk;
    logic refuse;
    logic accept;
    logic waitDone;
    logic exitIssue;
    logic issue;
    logic dllLoad;
    logic dllDone;
    logic [smr_pkg::ADDR_W-1:0] newWord;
    logic [smr_pkg::ADDR_W-1:0] exitWord;
    logic [smr_pkg::ADDR_W-1:0] wrField;
    logic [smr_pkg::ADDR_W-1:0] calField;
    logic [smr_pkg::ADDR_W-1:0] hotField;

    // command decode
    assign cmdWr = regWr && (regAddr == smr_pkg::ADDR_CMD);
    assign cmdTgt = regWrData[smr_pkg::CMD_TGT_LSB +: 2];
    assign cmdCal = regWrData[smr_pkg::CMD_CAL_BIT];
    assign cmdCode = regWrData[smr_pkg::CMD_CODE_LSB +: 3];

    // exit is issued by hardware itself, so software may not ask for it
    assign codeOk = (cmdCode == smr_pkg::CAL_DRIVE_HIGH)
        || (cmdCode == smr_pkg::CAL_DRIVE_LOW)
        || (cmdCode == smr_pkg::CAL_ADJUST) || (cmdCode == smr_pkg::CAL_DEFAULT);

    // refuse while busy, with open banks or clock enable low
    assign refuse = (state_q != smr_pkg::ST_IDLE)
        || !banksPrecharged || !clkEnHigh
        || (cmdCal && (cmdTgt != smr_pkg::TGT_EXT1 || !codeOk))
        || (cmdCal && cmdCode == smr_pkg::CAL_ADJUST
            && mainCfg_q[smr_pkg::BL_LSB +: 3] != smr_pkg::BL_FOUR);
    assign accept = cmdWr && !refuse;

    // register_write_cycle_time spacing between any two commands
    smr_wait_cnt #(
        .W(smr_pkg::CNT_W)
    ) u_mrd_cnt (
        .clk(clk),
        .rstn(rstn),
        .load(issue),
        .loadValue(smr_pkg::REGISTER_WRITE_CYCLE_TIME_LOAD),
        .value(),
        .done(waitDone)
    );

    assign exitIssue = (state_q == smr_pkg::ST_WAIT) && waitDone && pendExit_q;
    assign issue = accept || exitIssue;

    // address words of each target
    assign wrField = smr_pkg::ADDR_W'(smr_pkg::WR_CODE) << smr_pkg::WR_LSB;
    assign calField = smr_pkg::ADDR_W'(cmdCode) << smr_pkg::CAL_LSB;
    assign hotField = smr_pkg::ADDR_W'(ext2Hot_q) << smr_pkg::HOT_BIT;
    // shadow never holds calibration bits, so exit reuses it with latency intact
    assign exitWord = ext1Cfg_q;

    always_comb begin
        newWord = smr_pkg::ZERO_WORD;
        unique case (cmdTgt)
            smr_pkg::TGT_MAIN: newWord = mainCfg_q | wrField;
            smr_pkg::TGT_EXT1: newWord = cmdCal ? (ext1Cfg_q | calField) : ext1Cfg_q;
            smr_pkg::TGT_EXT2: newWord = hotField;
            smr_pkg::TGT_EXT3: newWord = smr_pkg::ZERO_WORD;
        endcase
    end

    // sequencer
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= smr_pkg::ST_IDLE;
        end else begin
            unique case (state_q)
                smr_pkg::ST_IDLE: begin
                    if (accept) begin
                        state_q <= smr_pkg::ST_WAIT;
                    end
                end
                smr_pkg::ST_WAIT: begin
                    if (waitDone && !pendExit_q) begin
                        state_q <= smr_pkg::ST_IDLE;
                    end
                end
            endcase
        end
    end

    // calibration exit owed after a calibration mode command
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pendExit_q <= 1'b0;
        end else if (accept && cmdCal) begin
            pendExit_q <= 1'b1;
        end else if (exitIssue) begin
            pendExit_q <= 1'b0;
        end
    end

    // command pins, one cycle per command, deselect otherwise
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            csN_q <= 1'b1;
            ba_q <= smr_pkg::TGT_MAIN;
            addr_q <= smr_pkg::ZERO_WORD;
        end else if (accept) begin
            csN_q <= 1'b0;
            ba_q <= cmdTgt; // and
            addr_q <= newWord;
        end else if (exitIssue) begin
            csN_q <= 1'b0;
            ba_q <= smr_pkg::TGT_EXT1;
            addr_q <= exitWord;
        end else begin
            csN_q <= 1'b1;
            ba_q <= smr_pkg::TGT_MAIN;
            addr_q <= smr_pkg::ZERO_WORD;
        end
    end

    assign ddrCsN = csN_q;
    assign ddrRasN = csN_q;
    assign ddrCasN = csN_q;
    assign ddrWeN = csN_q;
    assign ddrBa = ba_q;
    assign ddrAddr = addr_q;

    // software shadows; test and recovery bits are not software's to set
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mainCfg_q <= smr_pkg::MAIN_RESET;
            ext1Cfg_q <= smr_pkg::EXT1_RESET;
            ext2Hot_q <= 1'b0;
        end else if (regWr) begin
            if (regAddr == smr_pkg::ADDR_MAIN) begin
                mainCfg_q <= regWrData[smr_pkg::ADDR_W-1:0] & smr_pkg::MAIN_SW_MASK;
            end
            if (regAddr == smr_pkg::ADDR_EXT1) begin
                ext1Cfg_q <= regWrData[smr_pkg::ADDR_W-1:0] & smr_pkg::EXT1_SW_MASK;
            end
            if (regAddr == smr_pkg::ADDR_EXT2) begin
                ext2Hot_q <= regWrData[smr_pkg::HOT_BIT];
            end
        end
    end

    // hot case self refresh needs the fast rate already sent
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ext2HotSent_q <= 1'b0;
        end else if (accept && cmdTgt == smr_pkg::TGT_EXT2) begin
            ext2HotSent_q <= ext2Hot_q;
        end
    end

    assign selfRefreshOk = !hotCase || ext2HotSent_q;

    // refused command flag, cleared by the next accepted command
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            refused_q <= 1'b0;
        end else if (cmdWr && refuse) begin
            refused_q <= 1'b1;
        end else if (accept) begin
            refused_q <= 1'b0;
        end
    end

    // dll relock wait; self refresh exit resets the dll on the device too
    assign dllLoad = (accept && cmdTgt == smr_pkg::TGT_MAIN
        && mainCfg_q[smr_pkg::DLL_RESET_BIT]) || selfRefreshExit;

    smr_wait_cnt #(
        .W(smr_pkg::CNT_W)
    ) u_dll_cnt (
        .clk(clk),
        .rstn(rstn),
        .load(dllLoad),
        .loadValue(smr_pkg::DLL_LOAD),
        .value(),
        .done(dllDone)
    );

    assign readAllowed = dllDone;

    // read data, valid the cycle after the strobe only
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdData_q <= 32'h0000_0000;
        end else if (regRd) begin
            rdData_q <= 32'h0000_0000;
            unique case (regAddr)
                smr_pkg::ADDR_MAIN: rdData_q[smr_pkg::ADDR_W-1:0] <= mainCfg_q;
                smr_pkg::ADDR_EXT1: rdData_q[smr_pkg::ADDR_W-1:0] <= ext1Cfg_q;
                smr_pkg::ADDR_EXT2: rdData_q[smr_pkg::HOT_BIT] <= ext2Hot_q;
                smr_pkg::ADDR_STATUS: begin
                    rdData_q[smr_pkg::ST_BUSY_BIT] <= (state_q != smr_pkg::ST_IDLE);
                    rdData_q[smr_pkg::ST_READ_OK_BIT] <= dllDone;
                    rdData_q[smr_pkg::ST_REFUSED_BIT] <= refused_q;
                    rdData_q[smr_pkg::ST_SREF_OK_BIT] <= selfRefreshOk;
                    rdData_q[smr_pkg::ST_PEND_EXIT_BIT] <= pendExit_q;
                end
                default: rdData_q <= 32'h0000_0000;
            endcase
        end else begin
            rdData_q <= 32'h0000_0000;
        end
    end

    assign regRdData = rdData_q;

    // checks on the command pins
    logic cmdOnPins;
    logic [2:0] pinCal;
    assign cmdOnPins = !ddrCsN && !ddrRasN && !ddrCasN && !ddrWeN;
    assign pinCal = ddrAddr[smr_pkg::CAL_LSB +: 3];

    property p_test_low;
        @(posedge clk) disable iff (!rstn)
        (cmdOnPins && ddrBa == smr_pkg::TGT_MAIN) |-> !ddrAddr[smr_pkg::TEST_BIT];
    endproperty
    a_test_low: assert property (p_test_low) else $error("test bit high in main write");
    property p_wr_code;
        @(posedge clk) disable iff (!rstn)
        (cmdOnPins && ddrBa == smr_pkg::TGT_MAIN)
            |-> ddrAddr[smr_pkg::WR_LSB +: 3] == smr_pkg::WR_CODE;
    endproperty
    a_wr_code: assert property (p_wr_code) else $error("wrong write recovery code");
    property p_cmd_pulse;
        @(posedge clk) disable iff (!rstn)
        $fell(ddrCsN) |-> (!ddrRasN && !ddrCasN && !ddrWeN) ##1 (ddrCsN && ddrBa == 2'h0);
    endproperty
    a_cmd_pulse: assert property (p_cmd_pulse) else $error("command not one cycle");
    property p_main_target;
        @(posedge clk) disable iff (!rstn)
        (accept && cmdTgt == smr_pkg::TGT_MAIN) |=> (cmdOnPins && ddrBa == smr_pkg::TGT_MAIN);
    endproperty
    a_main_target: assert property (p_main_target) else $error("main write not on pins");
    property p_spacing;
        @(posedge clk) disable iff (!rstn)
        cmdOnPins |=> !cmdOnPins;
    endproperty
    a_spacing: assert property (p_spacing) else $error("commands closer than cycle time");
    property p_precond;
        @(posedge clk) disable iff (!rstn)
        (cmdOnPins && ddrBa != smr_pkg::TGT_MAIN && !$past(exitIssue))
            |-> $past(banksPrecharged) && $past(clkEnHigh);
    endproperty
    a_precond: assert property (p_precond) else $error("extended write with open banks");
    property p_dll_wait;
        @(posedge clk) disable iff (!rstn)
        (cmdOnPins && ddrBa == smr_pkg::TGT_MAIN && ddrAddr[smr_pkg::DLL_RESET_BIT])
            |-> !readAllowed [*8];
    endproperty
    a_dll_wait: assert property (p_dll_wait) else $error("read allowed during dll relock");

    property p_ext2_zero;
        @(posedge clk) disable iff (!rstn)
        (cmdOnPins && ddrBa == smr_pkg::TGT_EXT2)
            |-> (ddrAddr & ~(smr_pkg::ADDR_W'(1) << smr_pkg::HOT_BIT)) == smr_pkg::ZERO_WORD;
    endproperty
    a_ext2_zero: assert property (p_ext2_zero) else $error("ext two reserved bit set");

    property p_hot;
        @(posedge clk) disable iff (!rstn)
        (cmdOnPins && ddrBa == smr_pkg::TGT_EXT2) |-> ext2HotSent_q == ddrAddr[smr_pkg::HOT_BIT];
    endproperty
    a_hot: assert property (p_hot) else $error("self refresh allowed at slow rate");

    property p_ext3_zero;
        @(posedge clk) disable iff (!rstn)
        (cmdOnPins && ddrBa == smr_pkg::TGT_EXT3) |-> ddrAddr == smr_pkg::ZERO_WORD;
    endproperty
    a_ext3_zero: assert property (p_ext3_zero) else $error("ext three not zero");

    property p_cal_exit;
        @(posedge clk) disable iff (!rstn)
        (cmdOnPins && ddrBa == smr_pkg::TGT_EXT1 && pinCal != smr_pkg::CAL_EXIT)
            |-> ##2 (cmdOnPins && ddrBa == smr_pkg::TGT_EXT1 && pinCal == smr_pkg::CAL_EXIT);
    endproperty
    a_cal_exit: assert property (p_cal_exit) else $error("calibration exit missing");

    property p_adjust_bl4;
        @(posedge clk) disable iff (!rstn)
        (cmdOnPins && ddrBa == smr_pkg::TGT_EXT1 && pinCal == smr_pkg::CAL_ADJUST)
            |-> mainCfg_q[smr_pkg::BL_LSB +: 3] == smr_pkg::BL_FOUR;
    endproperty
    a_adjust_bl4: assert property (p_adjust_bl4) else $error("adjust without burst four");

    property p_plain_ext1;
        @(posedge clk) disable iff (!rstn)
        (cmdOnPins && ddrBa == smr_pkg::TGT_EXT1 && pinCal != smr_pkg::CAL_EXIT)
            |-> $past(accept) && $past(cmdCal);
    endproperty
    a_plain_ext1: assert property (p_plain_ext1) else $error("calibration code in plain write");

    property p_al_kept;
        @(posedge clk) disable iff (!rstn)
        (cmdOnPins && ddrBa == smr_pkg::TGT_EXT1)
            |-> ddrAddr[smr_pkg::AL_LSB +: 3] == ext1Cfg_q[smr_pkg::AL_LSB +: 3];
    endproperty
    a_al_kept: assert property (p_al_kept) else $error("additive latency changed");

endmodule // smr_ctrl

// [tb/smr_dev_model.sv]
// behavioural model of the memory's mode register logic
`timescale 1ns/100ps
module smr_dev_model (
    // clock
    input wire logic clk,
    // command pins
    input wire logic ddrCsN,
    input wire logic ddrRasN,
    input wire logic ddrCasN,
    input wire logic ddrWeN,
    input wire logic [1:0] ddrBa,
    input wire logic [12:0] ddrAddr,
    // observed state
    output logic [12:0] modeQ [4],
    output logic [2:0] calMode,
    output logic [7:0] calSeen,
    output logic [7:0] cmdCount,
    output logic [7:0] dllResets,
    output logic [17:0] padLevel
);
    logic [17:0] idlePat;
    wire isWrite = !ddrCsN && !ddrRasN && !ddrCasN && !ddrWeN;
    // register words start undefined, as on the real part
    initial begin
        calMode = 3'h0;
        calSeen = 8'h00;
        cmdCount = 8'h00;
        dllResets = 8'h00;
        idlePat = 18'h2aaaa;
    end
    always @(posedge clk) begin
        idlePat <= ~idlePat;
        if (isWrite) begin
            cmdCount <= cmdCount + 8'h01;
            modeQ[ddrBa] <= ddrAddr;
            if (ddrBa == 2'h0 && ddrAddr[8]) begin
                dllResets <= dllResets + 8'h01;
            end
            if (ddrBa == 2'h1) begin
                calMode <= ddrAddr[9:7];
                calSeen[ddrAddr[9:7]] <= 1'b1;
            end
        end
    end
    // released pads toggle so a stale level never passes for drive
    always_comb begin
        case (calMode)
            3'h1: padLevel = 18'h1ffff;
            3'h2: padLevel = 18'h20000;
            default: padLevel = idlePat;
        endcase
    end
endmodule // smr_dev_model

// [tb/tb_top.sv]
// self-checking bench for the mode register write controller
`timescale 1ns/100ps
module tb_top;
    logic clk, rstn, regWr, regRd, banksPrecharged, clkEnHigh, hotCase, selfRefreshExit;
    logic [7:0] regAddr, cnt, calSeen, cmdCount, dllResets;
    logic [31:0] regWrData, regRdData, v;
    logic readAllowed, selfRefreshOk, ddrCsN, ddrRasN, ddrCasN, ddrWeN;
    logic [1:0] ddrBa;
    logic [12:0] ddrAddr;
    logic [12:0] modeQ [4];
    logic [2:0] calMode;
    logic [17:0] padLevel;
    logic [2:0] codes [4] = '{3'h1, 3'h2, 3'h4, 3'h7};
    int errors, n_checks;

    smr_ctrl u_dut (.clk(clk), .rstn(rstn), .regAddr(regAddr), .regWrData(regWrData),
        .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
        .banksPrecharged(banksPrecharged), .clkEnHigh(clkEnHigh), .hotCase(hotCase),
        .selfRefreshExit(selfRefreshExit), .readAllowed(readAllowed),
        .selfRefreshOk(selfRefreshOk), .ddrCsN(ddrCsN), .ddrRasN(ddrRasN),
        .ddrCasN(ddrCasN), .ddrWeN(ddrWeN), .ddrBa(ddrBa), .ddrAddr(ddrAddr));
    smr_dev_model u_dev (.clk(clk), .ddrCsN(ddrCsN), .ddrRasN(ddrRasN), .ddrCasN(ddrCasN),
        .ddrWeN(ddrWeN), .ddrBa(ddrBa), .ddrAddr(ddrAddr), .modeQ(modeQ),
        .calMode(calMode), .calSeen(calSeen), .cmdCount(cmdCount),
        .dllResets(dllResets), .padLevel(padLevel));

    always #5 clk = ~clk;

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge clk);
        regWr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRd <= 1'b0;
        #1 v = regRdData;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // busy lasts past the automatic exit, so six cycles clear any command
    task automatic cmd(input logic [1:0] tgt, input logic cal, input logic [2:0] code);
        wr(smr_pkg::ADDR_CMD, {26'h0, code, cal, tgt});
        repeat (6) @(posedge clk);
    endtask
    task automatic final_report;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        final_report();
    end

    initial begin
        clk = 1'b0;
        rstn = 1'b0;
        {regWr, regRd, hotCase, selfRefreshExit} = 4'h0;
        {banksPrecharged, clkEnHigh} = 2'h3;
        regAddr = 8'h00;
        regWrData = 32'h0;
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        rd(smr_pkg::ADDR_STATUS);
        chk(v, 32'h0a);
        rd(smr_pkg::ADDR_MAIN);
        chk(v, 32'h32);
        rd(8'h20);
        chk(v, 32'h0);
        $display("test reset done");
        // burst 8, interleaved, latency 3, test bit set, dll reset
        wr(smr_pkg::ADDR_MAIN, 32'h1bb);
        rd(smr_pkg::ADDR_MAIN);
        chk(v, 32'h13b);
        cmd(smr_pkg::TGT_MAIN, 1'b0, 3'h0);
        v = 32'h13b | (32'(smr_pkg::WR_CODE) << 9);
        chk({19'h0, modeQ[0]}, v);
        chk({24'h0, dllResets}, 32'h1);
        // counter loaded at the accept edge: low through edge 199, high after edge 200
        repeat (193) @(posedge clk);
        #1 chk({31'h0, readAllowed}, 32'h0);
        @(posedge clk);
        #1 chk({31'h0, readAllowed}, 32'h1);
        @(posedge clk);
        selfRefreshExit <= 1'b1;
        @(posedge clk);
        selfRefreshExit <= 1'b0;
        repeat (199) @(posedge clk);
        #1 chk({31'h0, readAllowed}, 32'h0);
        @(posedge clk);
        #1 chk({31'h0, readAllowed}, 32'h1);
        $display("test main done");
        wr(smr_pkg::ADDR_EXT1, 32'h1fff);
        cmd(smr_pkg::TGT_EXT1, 1'b0, 3'h0);
        chk({19'h0, modeQ[1]}, 32'h0c7f);
        hotCase <= 1'b1;
        @(posedge clk);
        #1 chk({31'h0, selfRefreshOk}, 32'h0);
        wr(smr_pkg::ADDR_EXT2, 32'h1fff);
        cmd(smr_pkg::TGT_EXT2, 1'b0, 3'h0);
        chk({19'h0, modeQ[2]}, 32'h080);
        chk({31'h0, selfRefreshOk}, 32'h1);
        cmd(smr_pkg::TGT_EXT3, 1'b0, 3'h0);
        chk({19'h0, modeQ[3]}, 32'h0);
        $display("test ext done");
        // refusals: adjust at burst 8, bad code, wrong target, banks open, clock enable low, busy
        cnt = cmdCount;
        cmd(smr_pkg::TGT_EXT1, 1'b1, smr_pkg::CAL_ADJUST);
        rd(smr_pkg::ADDR_STATUS);
        chk(v & 32'h4, 32'h4);
        cmd(smr_pkg::TGT_EXT1, 1'b1, 3'h3);
        cmd(smr_pkg::TGT_MAIN, 1'b1, smr_pkg::CAL_DEFAULT);
        banksPrecharged <= 1'b0;
        cmd(smr_pkg::TGT_MAIN, 1'b0, 3'h0);
        banksPrecharged <= 1'b1;
        clkEnHigh <= 1'b0;
        cmd(smr_pkg::TGT_MAIN, 1'b0, 3'h0);
        clkEnHigh <= 1'b1;
        chk({24'h0, cmdCount}, {24'h0, cnt});
        // second command lands two edges after the first, still busy
        wr(smr_pkg::ADDR_MAIN, 32'h032);
        wr(smr_pkg::ADDR_CMD, 32'h0);
        cmd(smr_pkg::TGT_MAIN, 1'b0, 3'h0);
        chk({24'h0, cmdCount}, {24'h0, cnt + 8'h1});
        rd(smr_pkg::ADDR_STATUS);
        chk(v & 32'h4, 32'h4);
        wr(smr_pkg::ADDR_CMD, 32'h0);
        rd(smr_pkg::ADDR_STATUS);
        chk(v & 32'h5, 32'h1);
        rd(smr_pkg::ADDR_STATUS);
        chk(v & 32'h5, 32'h0);
        chk({24'h0, cmdCount}, {24'h0, cnt + 8'h2});
        $display("test refuse done");
        foreach (codes[i]) begin
            wr(smr_pkg::ADDR_CMD, {26'h0, codes[i], 3'h5});
            @(posedge clk);
            #1 chk({19'h0, modeQ[1]}, 32'h0c7f | (32'(codes[i]) << 7));
            if (codes[i] == 3'h1) chk({14'h0, padLevel}, 32'h1ffff);
            if (codes[i] == 3'h2) chk({14'h0, padLevel}, 32'h20000);
            repeat (5) @(posedge clk);
            chk({29'h0, calMode}, 32'h0);
        end
        // busy and owed exit both show while the exit is still to come
        wr(smr_pkg::ADDR_CMD, {26'h0, smr_pkg::CAL_DEFAULT, 3'h5});
        rd(smr_pkg::ADDR_STATUS);
        chk(v & 32'h11, 32'h11);
        repeat (5) @(posedge clk);
        chk({24'h0, calSeen}, 32'h97);
        chk({19'h0, modeQ[1]}, 32'h0c7f);
        $display("test calibration done");
        final_report();
    end
endmodule // tb_top
